// ==== meiu_core.v ====
`timescale 1ns/1ps
`include "meiu_map.vh"
module meiu_core (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Serial register port pins
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe,
    // Open-drain interrupt pin, active low
    output reg irq_n_o,
    output reg irq_n_oe,
    // Filtered channel samples, same clock
    input wire [23:0] voltage_sample,
    input wire voltage_valid,
    input wire [23:0] current_sample,
    input wire current_valid,
    // Temperature sensor path
    input wire [7:0] temp_code,
    output reg temp_route,
    // Zero-cross output
    output reg zero_cross_signal
);
    localparam T_IDLE = 3'b001;
    localparam T_WAIT = 3'b010;
    localparam T_CONV = 3'b100;
    localparam S_CMD = 3'b001;
    localparam S_RD = 3'b010;
    localparam S_WR = 3'b100;

    function [23:0] abs24;
        input [23:0] x;
        begin
            abs24 = x[23] ? (~x + 24'h000001) : x;
        end
    endfunction

    // Top byte after doubling
    function [7:0] top_doubled;
        input [23:0] a;
        begin
            top_doubled = a[22:15];
        end
    endfunction

    function [4:0] reg_width;
        input [5:0] addr;
        begin
            case (addr)
                `MEIU_ADDR_MODE, `MEIU_ADDR_IRQ_EN, `MEIU_ADDR_FLAGS, `MEIU_ADDR_FLAGS_RST: begin
                    reg_width = 5'h10;
                end
                `MEIU_ADDR_IMAX, `MEIU_ADDR_IMAX_RST, `MEIU_ADDR_VMAX, `MEIU_ADDR_VMAX_RST: begin
                    reg_width = 5'h18;
                end
                default: begin
                    reg_width = 5'h08;
                end
            endcase
        end
    endfunction

    wire sclk_s;
    wire cs_n_s;
    wire sdi_s;
    reg sclk_prev;
    reg [1:0] quarter_cnt;
    reg [23:0] v_cur;
    reg [23:0] i_cur;
    reg [15:0] mode;
    reg [15:0] irq_en;
    reg [15:0] flags;
    reg [7:0] dip_cycle_count;
    reg [7:0] dip_threshold;
    reg [7:0] voltage_peak_threshold;
    reg [7:0] current_peak_threshold;
    reg [23:0] voltage_max_hold;
    reg [23:0] current_max_hold;
    reg [7:0] temperature;
    reg above_seen;
    reg dip_active;
    reg [7:0] dip_cnt;
    reg [2:0] t_state;
    reg [4:0] t_cnt;
    reg [2:0] s_state;
    reg [7:0] cmd;
    reg [4:0] bit_cnt;
    reg [4:0] width;
    reg [23:0] shreg;
    reg release_win;
    reg clear_flags;
    reg clear_vmax;
    reg clear_imax;
    reg wr_mode;
    reg [15:0] events;
    reg [15:0] next_flags;
    reg [23:0] rd_data;

    wire tick = (quarter_cnt == `MEIU_QUARTER_DIV);
    wire fall = sclk_prev & ~sclk_s;
    wire rise = ~sclk_prev & sclk_s;
    wire [7:0] cmd_now = {cmd[6:0], sdi_s};
    wire [5:0] addr_now = cmd_now[5:0];
    wire [23:0] v_abs = abs24(voltage_sample);
    wire [23:0] i_abs = abs24(current_sample);
    wire zx_new = ~voltage_sample[23];
    wire zx_edge = voltage_valid & (zx_new != zero_cross_signal);
    wire zx_rise = zx_edge & zx_new;
    wire v_below = dip_threshold > top_doubled(v_abs);
    wire [7:0] dip_cnt_inc = dip_cnt + 8'h01;
    wire [7:0] dip_target = dip_cycle_count - 8'h01;
    wire temp_done = (t_state == T_CONV) & tick & (t_cnt == `MEIU_TEMP_DELAY - 5'h01);

    meiu_pin_sync u_sync_sclk (.clk(clk), .reset(reset), .pin(sclk), .level(sclk_s));
    meiu_pin_sync u_sync_cs (.clk(clk), .reset(reset), .pin(cs_n), .level(cs_n_s));
    meiu_pin_sync u_sync_sdi (.clk(clk), .reset(reset), .pin(sdi), .level(sdi_s));

    always @(posedge clk) begin
        if (reset) begin
            quarter_cnt <= 2'h0;
            sclk_prev <= 1'b0;
        end else begin
            quarter_cnt <= quarter_cnt + 2'h1;
            sclk_prev <= sclk_s;
        end
    end

    // Peak events computed per sample on both channels, each on its own valid strobe; dip events on the voltage channel only
    always @* begin
        events = 16'h0000;
        if (voltage_valid && top_doubled(v_abs) > voltage_peak_threshold) begin
            events[`MEIU_FLAG_PKV] = 1'b1;
        end
        if (current_valid && top_doubled(i_abs) > current_peak_threshold) begin
            events[`MEIU_FLAG_PKI] = 1'b1;
        end
        if (zx_edge) begin
            events[`MEIU_FLAG_ZX] = 1'b1;
        end
        if (zx_rise && !above_seen && !dip_active && dip_cycle_count > 8'h01 && dip_cnt_inc >= dip_target) begin
            events[`MEIU_FLAG_DIP] = 1'b1;
        end
        if (temp_done) begin
            events[`MEIU_FLAG_TEMP] = 1'b1;
        end
        // Set wins over a same-cycle clear; an event one cycle before the clear misses the read and is lost
        next_flags = (clear_flags ? 16'h0000 : flags) | events;
    end

    always @(posedge clk) begin
        if (reset) begin
            flags <= 16'h0000;
            irq_n_oe <= 1'b0;
            irq_n_o <= 1'b0;
        end else begin
            flags <= next_flags;
            irq_n_o <= 1'b0;
            irq_n_oe <= (|(flags & irq_en)) & ~release_win;
        end
    end

    // Zero crossing and dip cycle counting
    always @(posedge clk) begin
        if (reset) begin
            v_cur <= 24'h000000;
            i_cur <= 24'h000000;
            zero_cross_signal <= 1'b0;
            above_seen <= 1'b0;
            dip_active <= 1'b0;
            dip_cnt <= 8'h00;
        end else begin
            if (current_valid) begin
                i_cur <= current_sample;
            end
            if (voltage_valid) begin
                v_cur <= voltage_sample;
                zero_cross_signal <= zx_new;
                if (zx_rise) begin
                    above_seen <= ~v_below;
                    if (above_seen) begin
                        dip_cnt <= 8'h00;
                        dip_active <= 1'b0;
                    end else if (dip_cnt_inc >= dip_target && dip_cycle_count > 8'h01) begin
                        dip_active <= 1'b1;
                    end else begin
                        dip_cnt <= dip_cnt_inc;
                    end
                end else if (!v_below) begin
                    above_seen <= 1'b1;
                end
            end
        end
    end

    // Maximum holds, sampled on the quarter-rate tick; a fresh sample beats a clear
    always @(posedge clk) begin
        if (reset) begin
            voltage_max_hold <= 24'h000000;
            current_max_hold <= 24'h000000;
        end else begin
            if (tick && {abs24(v_cur), 1'b0} > {1'b0, (clear_vmax ? 24'h000000 : voltage_max_hold)}) begin
                voltage_max_hold <= {abs24(v_cur), 1'b0} > 25'hffffff ? 24'hffffff : {abs24(v_cur)} << 1;
            end else if (clear_vmax) begin
                voltage_max_hold <= 24'h000000;
            end
            if (tick && abs24(i_cur) > (clear_imax ? 24'h000000 : current_max_hold)) begin
                current_max_hold <= abs24(i_cur);
            end else if (clear_imax) begin
                current_max_hold <= 24'h000000;
            end
        end
    end

    // Temperature sequencing; sensor code is passed on raw, no calibration
    always @(posedge clk) begin
        if (reset) begin
            t_state <= T_IDLE;
            t_cnt <= 5'h00;
            temp_route <= 1'b0;
            temperature <= 8'h00;
        end else begin
            case (t_state)
                T_IDLE: begin
                    if (mode[`MEIU_MODE_TEMP_START]) begin
                        t_state <= T_WAIT;
                    end
                end
                T_WAIT: begin
                    if (zx_edge) begin
                        t_state <= T_CONV;
                        temp_route <= 1'b1;
                        t_cnt <= 5'h00;
                    end
                end
                T_CONV: begin
                    if (temp_done) begin
                        temperature <= temp_code;
                        temp_route <= 1'b0;
                        t_state <= T_IDLE;
                    end else if (tick) begin
                        t_cnt <= t_cnt + 5'h01;
                    end
                end
                default: begin
                    t_state <= T_IDLE;
                end
            endcase
        end
    end

    always @* begin
        case (addr_now)
            `MEIU_ADDR_MODE: rd_data = {8'h00, mode};
            `MEIU_ADDR_IRQ_EN: rd_data = {8'h00, irq_en};
            `MEIU_ADDR_FLAGS, `MEIU_ADDR_FLAGS_RST: rd_data = {8'h00, flags};
            `MEIU_ADDR_DIP_CYC: rd_data = {16'h0000, dip_cycle_count};
            `MEIU_ADDR_DIP_THR: rd_data = {16'h0000, dip_threshold};
            `MEIU_ADDR_VPK_THR: rd_data = {16'h0000, voltage_peak_threshold};
            `MEIU_ADDR_IPK_THR: rd_data = {16'h0000, current_peak_threshold};
            `MEIU_ADDR_IMAX, `MEIU_ADDR_IMAX_RST: rd_data = current_max_hold;
            `MEIU_ADDR_VMAX, `MEIU_ADDR_VMAX_RST: rd_data = voltage_max_hold;
            `MEIU_ADDR_TEMP: rd_data = {16'h0000, temperature};
            default: rd_data = 24'h000000;
        endcase
    end

    // Serial slave: bits taken on falling edges, driven out on rising edges
    always @(posedge clk) begin
        if (reset) begin
            s_state <= S_CMD;
            cmd <= 8'h00;
            bit_cnt <= 5'h00;
            width <= 5'h08;
            shreg <= 24'h000000;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            release_win <= 1'b0;
            clear_flags <= 1'b0;
            clear_vmax <= 1'b0;
            clear_imax <= 1'b0;
            wr_mode <= 1'b0;
            mode <= `MEIU_RST_MODE;
            irq_en <= `MEIU_RST_IRQ_EN;
            dip_cycle_count <= `MEIU_RST_DIP_CYC;
            dip_threshold <= `MEIU_RST_DIP_THR;
            voltage_peak_threshold <= `MEIU_RST_VPK_THR;
            current_peak_threshold <= `MEIU_RST_IPK_THR;
        end else begin
            clear_flags <= 1'b0;
            clear_vmax <= 1'b0;
            clear_imax <= 1'b0;
            wr_mode <= 1'b0;
            if (t_state == T_WAIT && zx_edge && !wr_mode) begin
                mode[`MEIU_MODE_TEMP_START] <= 1'b0;
            end
            if (cs_n_s) begin
                s_state <= S_CMD;
                bit_cnt <= 5'h00;
                sdo_oe <= 1'b0;
                release_win <= 1'b0;
            end else begin
                case (s_state)
                    S_CMD: begin
                        if (fall) begin
                            cmd <= cmd_now;
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == 5'h07) begin
                                bit_cnt <= 5'h00;
                                width <= reg_width(addr_now);
                                if (cmd_now[`MEIU_CMD_WRITE_BIT]) begin
                                    s_state <= S_WR;
                                end else begin
                                    s_state <= S_RD;
                                    shreg <= rd_data << (5'h18 - reg_width(addr_now));
                                    if (addr_now == `MEIU_ADDR_FLAGS_RST) begin
                                        release_win <= 1'b1;
                                        clear_flags <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    S_RD: begin
                        if (rise) begin
                            sdo <= shreg[23];
                            sdo_oe <= 1'b1;
                            shreg <= {shreg[22:0], 1'b0};
                        end else if (fall) begin
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == width - 5'h01) begin
                                bit_cnt <= 5'h00;
                                s_state <= S_CMD;
                                release_win <= 1'b0;
                                clear_vmax <= (cmd[5:0] == `MEIU_ADDR_VMAX_RST);
                                clear_imax <= (cmd[5:0] == `MEIU_ADDR_IMAX_RST);
                            end
                        end
                    end
                    S_WR: begin
                        if (fall) begin
                            shreg <= {shreg[22:0], sdi_s};
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == width - 5'h01) begin
                                bit_cnt <= 5'h00;
                                s_state <= S_CMD;
                                case (cmd[5:0])
                                    `MEIU_ADDR_MODE: begin
                                        mode <= {shreg[14:0], sdi_s};
                                        wr_mode <= 1'b1;
                                    end
                                    `MEIU_ADDR_IRQ_EN: irq_en <= {shreg[14:0], sdi_s};
                                    `MEIU_ADDR_DIP_CYC: dip_cycle_count <= {shreg[6:0], sdi_s};
                                    `MEIU_ADDR_DIP_THR: dip_threshold <= {shreg[6:0], sdi_s};
                                    `MEIU_ADDR_VPK_THR: voltage_peak_threshold <= {shreg[6:0], sdi_s};
                                    `MEIU_ADDR_IPK_THR: current_peak_threshold <= {shreg[6:0], sdi_s};
                                    default: begin
                                    end
                                endcase
                            end
                        end
                    end
                    default: begin
                        s_state <= S_CMD;
                    end
                endcase
            end
        end
    end
endmodule

// ==== meiu_core_chk.sv ====
`timescale 1ns/1ps
`include "meiu_map.vh"
module meiu_core_chk (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Serial port pins
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    input wire sdo_oe,
    // Interrupt pin
    input wire irq_n_o,
    input wire irq_n_oe,
    // Samples and status
    input wire [23:0] voltage_sample,
    input wire voltage_valid,
    input wire temp_route,
    input wire zero_cross_signal
);
    reg sclk_d;
    reg [5:0] nfall;
    reg [7:0] cmd;
    reg zc_d;
    reg zc_d2;
    reg [7:0] route_cnt;
    wire in_win;

    // Raw pin edges lead the filtered ones, so the window is taken a little short
    always @(posedge clk) begin
        sclk_d <= sclk;
        zc_d <= zero_cross_signal;
        zc_d2 <= zc_d;
        if (reset || !temp_route)
            route_cnt <= 8'h00;
        else
            route_cnt <= route_cnt + 8'h01;
        if (reset || cs_n) begin
            nfall <= 6'h00;
            cmd <= 8'h00;
        end else if (sclk_d && !sclk) begin
            nfall <= nfall + 6'h01;
            if (nfall < 6'h08)
                cmd <= {cmd[6:0], sdi};
        end
    end
    assign in_win = (cmd == {2'b00, `MEIU_ADDR_FLAGS_RST}) && (nfall >= 6'h09) && (nfall <= 6'h17);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    irq_drive_a: assert property (!irq_n_o)
        else $error("Interrupt pin drives a high level");
    irq_window_a: assert property (in_win |-> !irq_n_oe)
        else $error("Interrupt asserted during status transfer");
    zx_rise_a: assert property (voltage_valid && !voltage_sample[23] |=> zero_cross_signal)
        else $error("Zero cross low after non-negative sample");
    zx_fall_a: assert property (voltage_valid && voltage_sample[23] |=> !zero_cross_signal)
        else $error("Zero cross high after negative sample");
    zx_hold_a: assert property (!voltage_valid |=> $stable(zero_cross_signal))
        else $error("Zero cross moved without a sample");
    temp_start_a: assert property ($rose(temp_route) |-> (zero_cross_signal != zc_d) || (zc_d != zc_d2))
        else $error("Temperature started away from a zero crossing");
    temp_min_a: assert property ($rose(temp_route) |-> temp_route [*8])
        else $error("Temperature conversion cut short");
    temp_len_a: assert property ($fell(temp_route) |-> route_cnt inside {[90:100]})
        else $error("Temperature conversion length wrong");
    oe_idle_a: assert property (cs_n [*6] |-> !sdo_oe)
        else $error("Data output driven while deselected");
endmodule

// ==== meiu_host_model.sv ====
`timescale 1ns/1ps
`include "meiu_map.vh"
module meiu_host_model (
    // Bench clock
    input wire clk,
    // Serial port, host side
    output reg sclk,
    output reg cs_n,
    output reg sdi,
    input wire sdo,
    // Interrupt line after pull-up
    input wire irq_pin,
    output reg irq_seen
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
        irq_seen = 1'b0;
    end

    // Edge capture, so an event during service is not lost
    always @(negedge irq_pin) begin
        irq_seen = 1'b1;
    end

    // Phases of eight clocks leave margin over the pin filters
    task xfer(input [7:0] cmd, input integer n, input [23:0] wd, output [23:0] rd);
        reg [31:0] sh;
        integer i;
        begin
            sh = {cmd, wd << (24 - n)};
            rd = 24'h000000;
            @(negedge clk);
            cs_n = 1'b0;
            repeat (4) @(negedge clk);
            for (i = 0; i < 8 + n; i = i + 1) begin
                sdi = sh[31];
                sh = sh << 1;
                repeat (4) @(negedge clk);
                if (i >= 8)
                    rd = {rd[22:0], sdo};
                sclk = 1'b0;
                repeat (8) @(negedge clk);
                sclk = 1'b1;
                repeat (4) @(negedge clk);
            end
            cs_n = 1'b1;
            sdi = ~sdi;
            repeat (8) @(negedge clk);
        end
    endtask

    task service(output [23:0] st);
        begin
            irq_seen = 1'b0;
            xfer({2'b00, `MEIU_ADDR_FLAGS_RST}, 16, 24'h000000, st);
        end
    endtask
endmodule

// ==== meiu_map.vh ====
`ifndef MEIU_MAP_VH
`define MEIU_MAP_VH

// Register addresses (6-bit address field of the command byte)
`define MEIU_ADDR_MODE 6'h09
`define MEIU_ADDR_IRQ_EN 6'h0a
`define MEIU_ADDR_FLAGS 6'h0b
`define MEIU_ADDR_FLAGS_RST 6'h0c
`define MEIU_ADDR_DIP_CYC 6'h1e
`define MEIU_ADDR_DIP_THR 6'h1f
`define MEIU_ADDR_VPK_THR 6'h20
`define MEIU_ADDR_IPK_THR 6'h21
`define MEIU_ADDR_IMAX 6'h22
`define MEIU_ADDR_IMAX_RST 6'h23
`define MEIU_ADDR_VMAX 6'h24
`define MEIU_ADDR_VMAX_RST 6'h25
`define MEIU_ADDR_TEMP 6'h26

// Command byte fields
`define MEIU_CMD_WRITE_BIT 7

// Event flag positions
`define MEIU_FLAG_DIP 1
`define MEIU_FLAG_ZX 4
`define MEIU_FLAG_TEMP 5
`define MEIU_FLAG_PKV 8
`define MEIU_FLAG_PKI 9

// Mode register fields
`define MEIU_MODE_TEMP_START 5

// Reset values
`define MEIU_RST_MODE 16'h0000
`define MEIU_RST_IRQ_EN 16'h0000
`define MEIU_RST_DIP_CYC 8'hff
`define MEIU_RST_DIP_THR 8'h00
`define MEIU_RST_VPK_THR 8'hff
`define MEIU_RST_IPK_THR 8'hff

// Timing: quarter-rate divider and temperature delay in quarter-rate cycles
`define MEIU_QUARTER_DIV 2'h3
`define MEIU_TEMP_DELAY 5'h18

`endif

// ==== meiu_pin_sync.v ====
`timescale 1ns/1ps
module meiu_pin_sync (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Pin in, filtered level out
    input wire pin,
    output reg level
);
    reg stage1;
    reg stage2;
    reg stage3;

    // Level only moves once two later stages agree
    always @(posedge clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule

// ==== test_meiu_core.sv ====
`timescale 1ns/1ps
`include "meiu_map.vh"
module test_meiu_core;
    reg clk;
    reg reset;
    reg [23:0] voltage_sample;
    reg [23:0] current_sample;
    reg voltage_valid;
    reg current_valid;
    reg [7:0] temp_code;
    wire sclk, cs_n, sdi, sdo, sdo_oe, irq_n_o, irq_n_oe, temp_route, zero_cross_signal, irq_seen;
    wire irq_pin = irq_n_oe ? irq_n_o : 1'b1;
    integer error_cnt, comparisons, cycles, k, n;
    reg [23:0] rd;

    meiu_core uut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .voltage_sample(voltage_sample), .voltage_valid(voltage_valid),
        .current_sample(current_sample), .current_valid(current_valid), .temp_code(temp_code),
        .temp_route(temp_route), .zero_cross_signal(zero_cross_signal));
    // Undriven data line reads inverted, so a late output enable shows up
    meiu_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_oe ? sdo : ~sdo),
        .irq_pin(irq_pin), .irq_seen(irq_seen));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task check(input string what, input [23:0] seen, input [23:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task wr(input [5:0] a, input integer w, input [23:0] d);
        reg [23:0] unused;
        begin
            host.xfer({2'b10, a}, w, d, unused);
        end
    endtask

    task rd_chk(input [5:0] a, input integer w, input [23:0] exp);
        begin
            host.xfer({2'b00, a}, w, 24'h000000, rd);
            check($sformatf("register %h", a), rd, exp);
        end
    endtask

    // Bus values stay put after the strobe; the peak holds keep tracking the last strobed samples
    task sample(input [23:0] v, input [23:0] i, input vv, input iv);
        begin
            @(negedge clk);
            voltage_sample = v;
            current_sample = i;
            voltage_valid = vv;
            current_valid = iv;
            @(negedge clk);
            voltage_valid = 1'b0;
            current_valid = 1'b0;
            repeat (8) @(negedge clk);
        end
    endtask

    task wait_irq(input lvl);
        begin
            n = 0;
            while (irq_n_oe !== lvl && n < 40) begin
                @(negedge clk);
                n = n + 1;
            end
            check("irq_n_oe", {23'h0, irq_n_oe}, {23'h0, lvl});
        end
    endtask

    task complete_run;
        begin
            $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            error_cnt = error_cnt + 1;
            complete_run;
        end
    end

    initial begin
        reset = 1'b1;
        voltage_sample = 24'h000000;
        current_sample = 24'h000000;
        voltage_valid = 1'b0;
        current_valid = 1'b0;
        temp_code = 8'hc3;
        error_cnt = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
        rd_chk(`MEIU_ADDR_MODE, 16, 24'h000000);
        rd_chk(`MEIU_ADDR_IRQ_EN, 16, 24'h000000);
        rd_chk(`MEIU_ADDR_DIP_CYC, 8, 24'h0000ff);
        rd_chk(`MEIU_ADDR_DIP_THR, 8, 24'h000000);
        rd_chk(`MEIU_ADDR_VPK_THR, 8, 24'h0000ff);
        rd_chk(`MEIU_ADDR_IPK_THR, 8, 24'h0000ff);
        wr(6'h3f, 8, 24'h0000ff);
        rd_chk(6'h3f, 8, 24'h000000);
        wr(`MEIU_ADDR_FLAGS, 16, 24'h00ffff);
        rd_chk(`MEIU_ADDR_FLAGS, 16, 24'h000000);
        wr(`MEIU_ADDR_IMAX, 24, 24'h123456);
        rd_chk(`MEIU_ADDR_IMAX, 24, 24'h000000);
        $display("Test register map done");

        wr(`MEIU_ADDR_VPK_THR, 8, 24'h000040);
        wr(`MEIU_ADDR_IPK_THR, 8, 24'h000050);
        sample(24'h210000, 24'h280000, 1'b1, 1'b1);
        check("irq_n_oe", {23'h0, irq_n_oe}, 24'h000000);
        check("zero_cross", {23'h0, zero_cross_signal}, 24'h000001);
        rd_chk(`MEIU_ADDR_FLAGS, 16, 24'h000110);
        sample(24'h210000, 24'hd78000, 1'b0, 1'b1);
        rd_chk(`MEIU_ADDR_FLAGS_RST, 16, 24'h000310);
        rd_chk(`MEIU_ADDR_FLAGS, 16, 24'h000000);
        $display("Test peak detection done");

        // Zero samples first, else the holds refill from the channels after a clear
        sample(24'h000000, 24'h000000, 1'b1, 1'b1);
        rd_chk(`MEIU_ADDR_IMAX, 24, 24'h288000);
        rd_chk(`MEIU_ADDR_IMAX_RST, 24, 24'h288000);
        rd_chk(`MEIU_ADDR_IMAX, 24, 24'h000000);
        rd_chk(`MEIU_ADDR_VMAX_RST, 24, 24'h420000);
        rd_chk(`MEIU_ADDR_VMAX, 24, 24'h000000);
        $display("Test peak holds done");

        wr(`MEIU_ADDR_IRQ_EN, 16, 24'h000100);
        sample(24'h210000, 24'h000000, 1'b1, 1'b0);
        wait_irq(1'b1);
        check("irq_seen", {23'h0, irq_seen}, 24'h000001);
        fork
            host.service(rd);
            begin
                repeat (300) @(negedge clk);
                voltage_valid = 1'b1;
                @(negedge clk);
                voltage_valid = 1'b0;
            end
        join
        check("status", rd, 24'h000100);
        wait_irq(1'b1);
        check("irq_seen", {23'h0, irq_seen}, 24'h000001);
        host.service(rd);
        check("status", rd, 24'h000100);
        wait_irq(1'b0);
        sample(24'h000000, 24'hd78000, 1'b0, 1'b1);
        check("irq_n_oe", {23'h0, irq_n_oe}, 24'h000000);
        rd_chk(`MEIU_ADDR_FLAGS_RST, 16, 24'h000200);
        $display("Test interrupt service done");

        wr(`MEIU_ADDR_IRQ_EN, 16, 24'h000002);
        wr(`MEIU_ADDR_DIP_THR, 8, 24'h000020);
        wr(`MEIU_ADDR_DIP_CYC, 8, 24'h000003);
        for (k = 0; k < 5; k = k + 1) begin
            sample(24'h010000, 24'h000000, 1'b1, 1'b1);
            sample(24'hff0000, 24'h000000, 1'b1, 1'b1);
        end
        wait_irq(1'b1);
        host.xfer({2'b00, `MEIU_ADDR_FLAGS_RST}, 16, 24'h000000, rd);
        check("dip flag", rd & 24'h000002, 24'h000002);
        $display("Test dip detection done");

        wr(`MEIU_ADDR_IRQ_EN, 16, 24'h000020);
        wr(`MEIU_ADDR_MODE, 16, 24'h000020);
        sample(24'h010000, 24'h000000, 1'b1, 1'b0);
        check("temp_route", {23'h0, temp_route}, 24'h000001);
        n = 0;
        while (temp_route !== 1'b0 && n < 150) begin
            @(negedge clk);
            n = n + 1;
        end
        wait_irq(1'b1);
        rd_chk(`MEIU_ADDR_TEMP, 8, 24'h0000c3);
        rd_chk(`MEIU_ADDR_MODE, 16, 24'h000000);
        host.xfer({2'b00, `MEIU_ADDR_FLAGS_RST}, 16, 24'h000000, rd);
        check("temp flag", rd & 24'h000020, 24'h000020);
        $display("Test temperature done");
        complete_run;
    end
endmodule

bind meiu_core meiu_core_chk chk (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_oe(sdo_oe),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .voltage_sample(voltage_sample), .voltage_valid(voltage_valid),
    .temp_route(temp_route), .zero_cross_signal(zero_cross_signal));
